// File: watchdog_params.svh
// Offsets, field positions, reset values and timing counts of the watchdog
// How it works
// - Writing one to the enable bit turns the watchdog on and writing zero turns it off, within the guard rules.
// - A write that clears the enable bit is ignored unless the unlock bit currently reads one.
// - A zero written to the enable bit within four cycles of that unlock write disables the watchdog.
// - At safety level 2 no sequence of writes can stop the watchdog.
// - The three-bit selector picks 16K oscillator cycles for code 000, doubling per step to 2,048K.
// - At level 1 the watchdog starts off and a plain write of one to the enable bit turns it on.
// - At level 1 a timeout change or disable needs an unlock write then one write of enable and selector with unlock zero within four cycles.
// - At level 2 the watchdog always runs and the enable bit always reads one.
// - At level 2 a selector change needs the unlock write then a selector write with unlock zero within four cycles, its enable value ignored.
// - Hardware clears the unlock bit four cycles after it was written to one.
// - The fuse picks the level: unprogrammed gives level 1 starting off, programmed gives level 2 starting on.
// - A restart, a disable and a chip reset each return the timeout counter to zero.
// - An expired timeout without restart gives a reset pulse of one system clock cycle.
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

`define WDOG_ADDR_W 12
`define WDOG_CTRL_OFFSET 12'h000
`define WDOG_RESTART_OFFSET 12'h004
`define WDOG_STATUS_OFFSET 12'h008
`define WDOG_MASK_OFFSET 12'h00C
`define WDOG_COUNT_OFFSET 12'h010
`define WDOG_LEVEL_OFFSET 12'h014

`define WDOG_SEL_RESET 3'h0
`define WDOG_MASK_RESET 3'h0

`define WDOG_EV_EXPIRED 0
`define WDOG_EV_LAPSED 1
`define WDOG_EV_REFUSED 2

`define WDOG_LVL_LEVEL2_BIT 0
`define WDOG_LVL_LIVE_BIT 1

`define WDOG_UNLOCK_CYCLES 3'h4
`define WDOG_PCLK_HZ 40000000
`define WDOG_OSC_HZ 1000000
`define WDOG_OSC_DIV (`WDOG_PCLK_HZ / `WDOG_OSC_HZ)
`define WDOG_DIV_W 6
`define WDOG_BASE_OSC_CYCLES 16384
`define WDOG_CNT_W 22

`endif

// File: watchdog_pkg.sv
// Types shared by the watchdog files
package watchdog_pkg;

  typedef struct packed {
    logic [2:0] rsvd;
    logic change_unlock_bit;
    logic watchdog_on_bit;
    logic [2:0] timeout_select;
  } control_t;

  typedef struct packed {
    logic refused;
    logic lapsed;
    logic expired;
  } events_t;

  typedef enum logic [1:0] {
    BOOT_FILL,
    BOOT_SETTLE,
    BOOT_TAKE,
    BOOT_LIVE
  } boot_state_t;

endpackage : watchdog_pkg

// File: bit_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module bit_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : bit_sync

// File: timeout_counter.sv
// Watchdog timeout counter running on oscillator tick enables
`timescale 1ns/1ps
`include "watchdog_params.svh"
module timeout_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [`WDOG_CNT_W-1:0] limit,
  output logic [`WDOG_CNT_W-1:0] count,
  output logic expire
);
  logic at_end;

  assign at_end = (count >= limit - `WDOG_CNT_W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (clear) begin
        count <= '0;
      end else if (tick) begin
        if (at_end) begin
          count <= '0;
          expire <= 1'b1;
        end else begin
          count <= count + `WDOG_CNT_W'(1);
        end
      end
    end
  end
endmodule : timeout_counter

// File: watchdog_timed_config.sv
// Watchdog control register, timed unlock sequence and timeout reset
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_timed_config #(
  parameter int unsigned BASE_OSC_CYCLES = `WDOG_BASE_OSC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`WDOG_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic safety_level_fuse,
  output logic chip_reset_pulse,
  output logic irq,
  output logic watchdog_running
);

  // Boot capture of the fuse
  watchdog_pkg::boot_state_t boot_q;
  watchdog_pkg::boot_state_t boot_d;
  logic fuse_sync;
  logic level2_q;
  logic live;
  logic take_level;

  // Control state
  logic on_q;
  logic [2:0] sel_q;
  logic unlock_q;
  logic [2:0] win_q;
  logic on_eff;

  // Bus decode
  logic setup_rd;
  logic access;
  logic wr;
  logic rd_done;
  logic hit_ctrl;
  logic hit_restart;
  logic hit_status;
  logic hit_mask;
  logic hit_count;
  logic hit_level;
  logic mapped;
  watchdog_pkg::control_t wr_ctrl;
  watchdog_pkg::control_t rd_ctrl;
  logic [31:0] rd_mux;

  // Write classification
  logic ctrl_wr;
  logic unlock_wr;
  logic protected_wr;
  logic plain_wr;
  logic on_set_wr;
  logic clear_refused;
  logic sel_refused;
  logic window_end;

  // Counter and events
  logic [`WDOG_DIV_W-1:0] div_q;
  logic osc_tick;
  logic restart_wr;
  logic cnt_clear;
  logic expire;
  logic [`WDOG_CNT_W-1:0] count;
  logic [`WDOG_CNT_W-1:0] limit;
  watchdog_pkg::events_t status_q;
  watchdog_pkg::events_t mask_q;
  watchdog_pkg::events_t ev;
  logic status_rd;

  bit_sync u_fuse_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(safety_level_fuse),
    .sync_out(fuse_sync)
  );

  // Fuse level is sampled once the synchroniser has settled after release
  always_comb begin
    boot_d = boot_q;
    case (boot_q)
      watchdog_pkg::BOOT_FILL: begin
        boot_d = watchdog_pkg::BOOT_SETTLE;
      end
      watchdog_pkg::BOOT_SETTLE: begin
        boot_d = watchdog_pkg::BOOT_TAKE;
      end
      watchdog_pkg::BOOT_TAKE: begin
        boot_d = watchdog_pkg::BOOT_LIVE;
      end
      watchdog_pkg::BOOT_LIVE: begin
        boot_d = watchdog_pkg::BOOT_LIVE;
      end
      default: begin
        boot_d = watchdog_pkg::BOOT_FILL;
      end
    endcase
  end

  assign take_level = (boot_q == watchdog_pkg::BOOT_TAKE);
  assign live = (boot_q == watchdog_pkg::BOOT_LIVE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_q <= watchdog_pkg::BOOT_FILL;
    end else begin
      boot_q <= boot_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level2_q <= 1'b0;
    end else if (take_level) begin
      level2_q <= fuse_sync;
    end
  end

  // APB decode; the bus is held off until the fuse level is known
  assign pready = live;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access = psel & penable & live;
  assign wr = access & pwrite & mapped;
  assign rd_done = access & ~pwrite;
  assign hit_ctrl = (paddr == `WDOG_CTRL_OFFSET);
  assign hit_restart = (paddr == `WDOG_RESTART_OFFSET);
  assign hit_status = (paddr == `WDOG_STATUS_OFFSET);
  assign hit_mask = (paddr == `WDOG_MASK_OFFSET);
  assign hit_count = (paddr == `WDOG_COUNT_OFFSET);
  assign hit_level = (paddr == `WDOG_LEVEL_OFFSET);
  assign mapped = hit_ctrl | hit_restart | hit_status | hit_mask | hit_count | hit_level;
  assign pslverr = access & ~mapped;
  assign wr_ctrl = watchdog_pkg::control_t'(pwdata[7:0]);

  // Write classification against the unlock window
  assign ctrl_wr = wr & hit_ctrl;
  assign unlock_wr = ctrl_wr & wr_ctrl.change_unlock_bit & wr_ctrl.watchdog_on_bit;
  assign protected_wr = ctrl_wr & ~wr_ctrl.change_unlock_bit & unlock_q;
  assign plain_wr = ctrl_wr & ~unlock_wr & ~protected_wr;
  assign on_set_wr = ctrl_wr & wr_ctrl.watchdog_on_bit;
  assign clear_refused = plain_wr & ~wr_ctrl.watchdog_on_bit & on_eff;
  assign sel_refused = plain_wr & (wr_ctrl.timeout_select != sel_q);
  assign window_end = unlock_q & (win_q == 3'h1) & ~protected_wr;

  // Level 2 forces the enable high everywhere it is seen
  assign on_eff = on_q | level2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
    end else if (take_level) begin
      on_q <= fuse_sync;
    end else if (protected_wr) begin
      on_q <= wr_ctrl.watchdog_on_bit | level2_q;
    end else if (on_set_wr) begin
      on_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= `WDOG_SEL_RESET;
    end else if (protected_wr) begin
      sel_q <= wr_ctrl.timeout_select;
    end
  end

  // Unlock window: four system cycles after the unlock write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= 1'b0;
      win_q <= 3'h0;
    end else if (unlock_wr) begin
      unlock_q <= 1'b1;
      win_q <= `WDOG_UNLOCK_CYCLES;
    end else if (protected_wr) begin
      unlock_q <= 1'b0;
      win_q <= 3'h0;
    end else if (unlock_q) begin
      win_q <= win_q - 3'h1;
      unlock_q <= (win_q != 3'h1);
    end
  end

  // Oscillator tick derived from the system clock
  assign osc_tick = (div_q == `WDOG_DIV_W'(`WDOG_OSC_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (osc_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + `WDOG_DIV_W'(1);
    end
  end

  // Timeout length doubles with each selector step
  assign limit = `WDOG_CNT_W'(BASE_OSC_CYCLES) << sel_q;
  assign restart_wr = wr & hit_restart;
  assign cnt_clear = restart_wr | ~on_eff | ~live;

  timeout_counter u_timeout (
    .clk(pclk),
    .rst_n(presetn),
    .tick(osc_tick),
    .clear(cnt_clear),
    .limit(limit),
    .count(count),
    .expire(expire)
  );

  // Pulse comes straight from the counter flop, one cycle wide
  assign chip_reset_pulse = expire;
  assign watchdog_running = on_eff & live;

  // Sticky events; a new event wins over the read that clears
  // Only bits the read returned are cleared, so a late event is not lost
  assign ev.expired = expire;
  assign ev.lapsed = window_end;
  assign ev.refused = clear_refused | sel_refused;
  assign status_rd = rd_done & hit_status;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else if (status_rd) begin
      status_q <= (status_q & ~watchdog_pkg::events_t'(prdata[2:0])) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `WDOG_MASK_RESET;
    end else if (wr & hit_mask) begin
      mask_q <= watchdog_pkg::events_t'(pwdata[2:0]);
    end
  end

  assign irq = |(status_q & mask_q);

  // Read view of the control register
  assign rd_ctrl.rsvd = 3'h0;
  assign rd_ctrl.change_unlock_bit = unlock_q;
  assign rd_ctrl.watchdog_on_bit = on_eff;
  assign rd_ctrl.timeout_select = sel_q;

  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {24'h0, rd_ctrl};
    end else if (hit_status) begin
      rd_mux = {29'h0, status_q};
    end else if (hit_mask) begin
      rd_mux = {29'h0, mask_q};
    end else if (hit_count) begin
      rd_mux = {10'h0, count};
    end else if (hit_level) begin
      rd_mux[`WDOG_LVL_LEVEL2_BIT] = level2_q;
      rd_mux[`WDOG_LVL_LIVE_BIT] = live;
      rd_mux[4:2] = win_q;
    end
  end

  // Read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

endmodule : watchdog_timed_config

// File: watchdog_timed_config_asserts.sv
// Port checker for the watchdog control block
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_timed_config_asserts #(
  parameter int unsigned BASE_OSC_CYCLES = `WDOG_BASE_OSC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic safety_level_fuse,
  input wire logic chip_reset_pulse,
  input wire logic irq,
  input wire logic watchdog_running
);
  wire acc = psel && penable && pready;
  wire ctl = acc && paddr == `WDOG_CTRL_OFFSET;
  // Cycles since the last unlock write, saturating so old windows stay shut
  logic [2:0] since_q;
  logic [2:0] since_d;
  assign since_d = (ctl && pwrite && pwdata[4] && pwdata[3]) ? 3'h1 :
    since_q + {2'h0, since_q != 3'h7};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_q <= 3'h7;
    else since_q <= since_d;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pulse_one; chip_reset_pulse |=> !chip_reset_pulse; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");
  property p_pulse_run; chip_reset_pulse |-> $past(watchdog_running); endproperty
  a_pulse_run: assert property (p_pulse_run) else $error("pulse while idle");
  property p_l2_run; safety_level_fuse && pready |-> watchdog_running; endproperty
  a_l2_run: assert property (p_l2_run) else $error("level 2 stopped");
  property p_start_off; $rose(pready) && !safety_level_fuse |-> !watchdog_running; endproperty
  a_start_off: assert property (p_start_off) else $error("level 1 starts on");
  property p_l2_read; ctl && !pwrite && safety_level_fuse |-> prdata[3]; endproperty
  a_l2_read: assert property (p_l2_read) else $error("enable reads 0");
  property p_off_win;
    $fell(watchdog_running) |-> $past(ctl && pwrite && pwdata[4:3] == 2'h0)
      && $past(since_q) inside {[3'h1:3'h4]};
  endproperty
  a_off_win: assert property (p_off_win) else $error("stop outside window");
  property p_unlock_on; ctl && pwrite && pwdata[4] && pwdata[3] |=> watchdog_running; endproperty
  a_unlock_on: assert property (p_unlock_on) else $error("enable ignored");
  property p_err;
    psel && penable |-> pslverr == (pready && !(paddr inside {`WDOG_CTRL_OFFSET,
      `WDOG_RESTART_OFFSET, `WDOG_STATUS_OFFSET, `WDOG_MASK_OFFSET, `WDOG_COUNT_OFFSET,
      `WDOG_LEVEL_OFFSET}));
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  c_off: cover property ($fell(watchdog_running));
  c_pulse: cover property (chip_reset_pulse);
  c_irq: cover property ($rose(irq));
endmodule : watchdog_timed_config_asserts

bind watchdog_timed_config watchdog_timed_config_asserts #(
  .BASE_OSC_CYCLES(BASE_OSC_CYCLES)
) i_asserts (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .safety_level_fuse, .chip_reset_pulse, .irq, .watchdog_running);

// File: watchdog_timed_config_test.sv
// Self-checking bench for the watchdog control block
`timescale 1ns/1ps
`include "watchdog_params.svh"
module watchdog_timed_config_test;
  logic pclk, presetn, psel, penable, pwrite, safety_level_fuse, m_en, m_l2, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, m_st;
  logic pready, pslverr, chip_reset_pulse, irq, watchdog_running;
  logic [2:0] m_sel, s;
  int n_fail, checked, npulse, at, m_win, seed, p;
  // Short base count keeps the longest timeout at 512 oscillator ticks, 20,480 cycles
  watchdog_timed_config #(.BASE_OSC_CYCLES(4)) i_dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .safety_level_fuse,
    .chip_reset_pulse, .irq, .watchdog_running);
  always #12.5 pclk = ~pclk;
  // Counted mid-cycle, where the one-cycle pulse stands settled
  always @(negedge pclk) begin
    if (chip_reset_pulse === 1'b1) npulse++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    at = int'($time / 25);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Model: unlock opens a window, protected write must land within four cycles
  task automatic wctl(input logic [7:0] d);
    apb(1'b1, `WDOG_CTRL_OFFSET, {24'h0, d});
    if (d[4] && d[3]) begin
      m_win = at;
      m_en = 1'b1;
    end else if (m_win >= 0 && at - m_win <= 4 && !d[4]) begin
      m_sel = d[2:0];
      m_en = m_l2 | d[3];
      m_win = -1;
    end else if ((!d[3] && m_en) || d[2:0] != m_sel) begin
      m_st[2] = 1'b1;
      m_en = m_en | d[3];
    end else begin
      m_en = m_en | d[3];
    end
  endtask : wctl
  task automatic rctl(input logic ub);
    apb(1'b0, `WDOG_CTRL_OFFSET, 32'h0);
    chk(rd, {27'h0, ub, m_en, m_sel});
  endtask : rctl
  task automatic rst(input logic l2);
    presetn <= 1'b0;
    safety_level_fuse <= l2;
    m_l2 = l2;
    m_en = l2;
    m_sel = 3'h0;
    m_win = -1;
    m_st = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : rst
  task automatic end_of_test();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    #1500000;
    n_fail++;
    end_of_test();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, safety_level_fuse} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'h0516F343;
    @(posedge pclk);
    rst(1'b0);
    rctl(1'b0);
    wctl(8'h08);
    chk(watchdog_running, m_en);
    wctl(8'h00);
    @(negedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, `WDOG_MASK_OFFSET, 32'h4);
    chk(irq, 1'b1);
    apb(1'b0, `WDOG_STATUS_OFFSET, 32'h0);
    chk(rd & 32'h4, m_st);
    m_st = 32'h0;
    chk(irq, 1'b0);
    wctl(8'h18);
    rctl(1'b1);
    repeat (6) @(posedge pclk);
    rctl(1'b0);
    wctl(8'h18);
    repeat (6) @(posedge pclk);
    wctl(8'h00);
    wctl(8'h10);
    wctl(8'h00);
    chk(watchdog_running, 1'b1);
    apb(1'b1, `WDOG_RESTART_OFFSET, 32'h0);
    repeat (2) @(posedge pclk);
    p = npulse;
    repeat (6) begin
      repeat (90) @(posedge pclk);
      apb(1'b1, `WDOG_RESTART_OFFSET, 32'h0);
    end
    chk(npulse, p);
    repeat (3) begin
      s = 3'($random(seed) & 3);
      wctl({5'h03, m_sel});
      wctl({5'h01, s});
      rctl(1'b0);
      p = npulse;
      apb(1'b1, `WDOG_RESTART_OFFSET, 32'h0);
      at = 0;
      while (npulse == p && at < 2000) begin
        @(negedge pclk);
        at++;
      end
      // Oscillator tick phase is free, so allow one tick of slack
      chk(at > 40 * (4 << s) - 46 && at < 40 * (4 << s) + 8, 1'b1);
    end
    wctl({5'h03, m_sel});
    wctl(8'h00);
    chk(watchdog_running, 1'b0);
    p = npulse;
    repeat (400) @(posedge pclk);
    chk(npulse, p);
    apb(1'b0, `WDOG_COUNT_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk(err, 1'b1);
    rst(1'b1);
    rctl(1'b0);
    apb(1'b0, `WDOG_LEVEL_OFFSET, 32'h0);
    chk(rd, 32'h3);
    wctl(8'h00);
    wctl(8'h18);
    wctl(8'h02);
    rctl(1'b0);
    chk(watchdog_running, 1'b1);
    end_of_test();
  end
endmodule : watchdog_timed_config_test
